// ### logic/ddu_chan.sv
/*
  One converter channel: control register, held data bytes and the
  converter input latch with its update trigger.
  Assumes write strobes and timer overflows are one-cycle pulses on clk.
*/
`timescale 1ns/1ns
module ddu_chan
  import ddu_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Decoder side
  ddu_chan_if.chan cif
);

  typedef struct packed {
    ddu_ctl_t ctl;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [11:0] code;
  } ddu_chan_st_t;

  ddu_chan_st_t st_q;
  ddu_chan_st_t st_d;
  logic tick;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Timer overflow picked by the update-mode field
  always_comb begin
    case (st_q.ctl.mode)
      DDU_UPD_TIMER3: tick = cif.tmr3_ovf; // RULE9
      DDU_UPD_TIMER4: tick = cif.tmr4_ovf; // RULE9
      DDU_UPD_TIMER2: tick = cif.tmr2_ovf; // RULE9
      default: tick = 1'b0;
    endcase
  end

  // Old format is used when a control write meets an update edge
  always_comb begin
    st_d = st_q;
    if (cif.wr_lo) begin
      st_d.lo = cif.wdata; // RULE5 RULE17
    end
    if (cif.wr_hi) begin
      st_d.hi = cif.wdata;
    end
    if (cif.wr_ctl) begin
      st_d.ctl = '{en: cif.wdata[DDU_EN_BIT], unused: 2'b00, // RULE3 RULE15 RULE18
                   mode: ddu_mode_t'(cif.wdata[DDU_MODE_LSB +: 2]),
                   fmt: cif.wdata[DDU_FMT_LSB +: 3]};
    end
    if (st_q.ctl.mode == DDU_UPD_HIWRITE) begin
      if (cif.wr_hi) begin
        st_d.code = ddu_assemble(cif.wdata, st_q.lo, st_q.ctl.fmt); // RULE4 RULE19
      end
    end else if (tick) begin
      // Writes coinciding with the overflow land after it: bytes stay held
      st_d.code = ddu_assemble(st_q.hi, st_q.lo, st_q.ctl.fmt); // RULE8 RULE19
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= '{ctl: DDU_CTL_RESET, hi: DDU_BYTE_RESET, lo: DDU_BYTE_RESET,
                code: DDU_CODE_RESET};
    end else begin
      st_q <= st_d;
    end
  end

  // Full 0x000..0xfff code reaches the converter untouched
  assign cif.code = st_q.code; // RULE1
  assign cif.ctl = st_q.ctl;
  assign cif.hi = st_q.hi;
  assign cif.lo = st_q.lo;

endmodule

// ### logic/ddu_chan_if.sv
/*
  Carrier between the register decoder and one converter channel.
  Assumes the decoder raises at most one write strobe per cycle.
*/
`timescale 1ns/1ns
interface ddu_chan_if;
  import ddu_pkg::*;
  logic wr_ctl;
  logic wr_hi;
  logic wr_lo;
  logic [7:0] wdata;
  logic tmr2_ovf;
  logic tmr3_ovf;
  logic tmr4_ovf;
  ddu_ctl_t ctl;
  logic [7:0] hi;
  logic [7:0] lo;
  logic [11:0] code;

  modport dec (
    output wr_ctl, wr_hi, wr_lo, wdata, tmr2_ovf, tmr3_ovf, tmr4_ovf,
    input ctl, hi, lo, code
  );
  modport chan (
    input wr_ctl, wr_hi, wr_lo, wdata, tmr2_ovf, tmr3_ovf, tmr4_ovf,
    output ctl, hi, lo, code
  );
endinterface

// ### logic/ddu_pkg.sv
/*
  Shared constants, types and the data-word assembly function for the
  dual converter update control block.
  Assumes a byte-wide special-function-register bus with paged addressing.
*/
package ddu_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] DDU_CTL_ADDR = 8'hd4; // Control register, both pages
  localparam logic [7:0] DDU_LO_ADDR = 8'hd2; // Low data byte
  localparam logic [7:0] DDU_HI_ADDR = 8'hd3; // High data byte
  localparam logic [7:0] DDU_CHAN0_PAGE = 8'h00;
  localparam logic [7:0] DDU_CHAN1_PAGE = 8'h01;
  localparam int DDU_NUM_CHAN = 2;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int DDU_EN_BIT = 7;
  localparam int DDU_MODE_LSB = 3;
  localparam int DDU_FMT_LSB = 0;
  localparam logic [7:0] DDU_CTL_RESET = 8'h00;
  localparam logic [7:0] DDU_BYTE_RESET = 8'h00;
  localparam logic [11:0] DDU_CODE_RESET = 12'h000;
  localparam logic [7:0] DDU_UNMAPPED_READ = 8'h00;

  // Update trigger selection
  typedef enum logic [1:0] {
    DDU_UPD_HIWRITE = 2'b00,
    DDU_UPD_TIMER3 = 2'b01,
    DDU_UPD_TIMER4 = 2'b10,
    DDU_UPD_TIMER2 = 2'b11
  } ddu_mode_t;

  // Control register image; the two unused bits always hold zero
  typedef struct packed {
    logic en;
    logic [1:0] unused;
    ddu_mode_t mode;
    logic [2:0] fmt;
  } ddu_ctl_t;

  // Build the 12-bit word from the two bytes under a justification setting
  function automatic logic [11:0] ddu_assemble(input logic [7:0] hi, input logic [7:0] lo,
                                               input logic [2:0] fmt);
    logic [11:0] w;
    w = {hi[3:0], lo};
    if (fmt[2]) begin
      w = {hi, lo[7:4]}; // RULE14
    end else begin
      case (fmt[1:0])
        2'b00: w = {hi[3:0], lo}; // RULE10
        2'b01: w = {hi[4:0], lo[7:1]}; // RULE11
        2'b10: w = {hi[5:0], lo[7:2]}; // RULE12
        2'b11: w = {hi[6:0], lo[7:3]}; // RULE13
        default: w = {hi[3:0], lo};
      endcase
    end
    return w;
  endfunction

endpackage

// ### logic/ddu_top.sv
/*
  Dual 12-bit converter update control: paged register decode, two
  channels, registered read data and per-channel enable outputs.
  Assumes a processor core on a byte-wide register bus synchronous to clk,
  and timer overflow inputs that are one-cycle pulses on clk.
*/
// Functional notes
// [RULE1] Each channel takes a full 12-bit unsigned code from 0x000 to 0xfff.
// [RULE2] Disabled channel: output pin high impedance and channel powered down.
// [RULE3] Control bit 7 enables the channel; zero disables and shuts down.
// [RULE4] Update mode 00, the default, updates output on each high-byte write.
// [RULE5] In mode 00 a low-byte write is only stored until a high-byte write.
// [RULE6] Software writes low byte first, then high byte, for full 12 bits.
// [RULE7] For 8-bit use software sets low byte once, then writes high only.
// [RULE8] Nonzero mode holds both bytes; selected overflow copies them to latch.
// [RULE9] Mode 00 high write, 01 timer 3, 10 timer 4, 11 timer 2 overflow.
// [RULE10] Format 000: high bits 3..0 over the whole low byte.
// [RULE11] Format 001: high bits 4..0 over low bits 7..1.
// [RULE12] Format 010: high bits 5..0 over low bits 7..2.
// [RULE13] Format 011: high bits 6..0 over low bits 7..3.
// [RULE14] Format 1xx: whole high byte over low bits 7..4.
// [RULE15] Control bits 6 and 5 read zero and ignore writes.
// [RULE16] Second channel behaves like the first with its own three registers.
// [RULE17] Second channel low byte is read/write, resets to zero.
// [RULE18] Second channel control has the same layout, resets to zero.
// [RULE19] Format in force at the update event builds the 12-bit word.
`timescale 1ns/1ns
module ddu_top
  import ddu_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register bus
  input wire logic [7:0] sfr_page,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Timer overflow pulses
  input wire logic tmr2_ovf,
  input wire logic tmr3_ovf,
  input wire logic tmr4_ovf,
  // Converter side
  output logic [11:0] chan0_code,
  output logic [11:0] chan1_code,
  output logic chan0_enable,
  output logic chan1_enable
);

  typedef struct packed {
    logic [7:0] rdata;
  } ddu_top_st_t;

  ddu_top_st_t st_q;
  ddu_top_st_t st_d;
  logic [DDU_NUM_CHAN-1:0] page_hit;

  ddu_chan_if cif [DDU_NUM_CHAN] ();

  // ----------------------------------------------------------------
  // Channels and write decode
  // ----------------------------------------------------------------
  for (genvar g = 0; g < DDU_NUM_CHAN; g++) begin : g_chan
    // Each page owns one identical channel
    assign page_hit[g] = (sfr_page == 8'(g)); // RULE16
    assign cif[g].wr_ctl = sfr_wr && page_hit[g] && (sfr_addr == DDU_CTL_ADDR);
    assign cif[g].wr_hi = sfr_wr && page_hit[g] && (sfr_addr == DDU_HI_ADDR);
    assign cif[g].wr_lo = sfr_wr && page_hit[g] && (sfr_addr == DDU_LO_ADDR);
    assign cif[g].wdata = sfr_wdata;
    assign cif[g].tmr2_ovf = tmr2_ovf;
    assign cif[g].tmr3_ovf = tmr3_ovf;
    assign cif[g].tmr4_ovf = tmr4_ovf;

    ddu_chan u_chan (
      .clk(clk),
      .reset(reset),
      .cif(cif[g])
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_hiwrite_update: assert property (@(posedge clk) disable iff (reset) // RULE4
      (cif[g].wr_hi && cif[g].ctl.mode == DDU_UPD_HIWRITE) |=>
        cif[g].code == ddu_assemble($past(sfr_wdata), $past(cif[g].lo),
                                    $past(cif[g].ctl.fmt)))
      else $error("high write did not update code");

    a_lowrite_held: assert property (@(posedge clk) disable iff (reset) // RULE5
      (cif[g].wr_lo && cif[g].ctl.mode == DDU_UPD_HIWRITE) |=>
        ($stable(cif[g].code) && cif[g].lo == $past(sfr_wdata)))
      else $error("low write changed code");

    a_timer_update: assert property (@(posedge clk) disable iff (reset) // RULE8
      (cif[g].ctl.mode == DDU_UPD_TIMER3 && tmr3_ovf) |=>
        cif[g].code == ddu_assemble($past(cif[g].hi), $past(cif[g].lo),
                                    $past(cif[g].ctl.fmt)))
      else $error("timer 3 overflow did not update code");

    a_timer4_update: assert property (@(posedge clk) disable iff (reset) // RULE8 RULE9
      (cif[g].ctl.mode == DDU_UPD_TIMER4 && tmr4_ovf) |=>
        cif[g].code == ddu_assemble($past(cif[g].hi), $past(cif[g].lo),
                                    $past(cif[g].ctl.fmt)))
      else $error("timer 4 overflow did not update code");

    a_timer2_update: assert property (@(posedge clk) disable iff (reset) // RULE8 RULE9
      (cif[g].ctl.mode == DDU_UPD_TIMER2 && tmr2_ovf) |=>
        cif[g].code == ddu_assemble($past(cif[g].hi), $past(cif[g].lo),
                                    $past(cif[g].ctl.fmt)))
      else $error("timer 2 overflow did not update code");

    a_timer_hold: assert property (@(posedge clk) disable iff (reset) // RULE8
      (cif[g].ctl.mode != DDU_UPD_HIWRITE &&
       !(cif[g].ctl.mode == DDU_UPD_TIMER2 && tmr2_ovf) &&
       !(cif[g].ctl.mode == DDU_UPD_TIMER3 && tmr3_ovf) &&
       !(cif[g].ctl.mode == DDU_UPD_TIMER4 && tmr4_ovf)) |=> $stable(cif[g].code))
      else $error("code changed without selected overflow");

    a_timer_select: assert property (@(posedge clk) disable iff (reset) // RULE9
      (cif[g].ctl.mode == DDU_UPD_TIMER4 && tmr2_ovf && !tmr4_ovf) |=>
        $stable(cif[g].code))
      else $error("wrong timer triggered update");

    a_unused_zero: assert property (@(posedge clk) disable iff (reset) // RULE15
      cif[g].wr_ctl |=> (cif[g].ctl.unused == 2'b00 &&
                         cif[g].ctl.en == $past(sfr_wdata[DDU_EN_BIT])))
      else $error("control write layout wrong");

    a_fmt_wide: assert property (@(posedge clk) disable iff (reset) // RULE14
      (cif[g].wr_hi && cif[g].ctl.mode == DDU_UPD_HIWRITE && cif[g].ctl.fmt[2]) |=>
        cif[g].code[11:4] == $past(sfr_wdata))
      else $error("format 1xx misplaced high byte");

    a_fmt_nibble: assert property (@(posedge clk) disable iff (reset) // RULE10
      (cif[g].wr_hi && cif[g].ctl.mode == DDU_UPD_HIWRITE && cif[g].ctl.fmt == 3'b000)
        |=> cif[g].code == {$past(sfr_wdata[3:0]), $past(cif[g].lo)})
      else $error("format 000 misplaced bits");

    // Explicit bit windows, independent of the shared assembly function
    a_fmt_five: assert property (@(posedge clk) disable iff (reset) // RULE11
      (cif[g].wr_hi && cif[g].ctl.mode == DDU_UPD_HIWRITE && cif[g].ctl.fmt == 3'b001)
        |=> cif[g].code == {$past(sfr_wdata[4:0]), $past(cif[g].lo[7:1])})
      else $error("format 001 misplaced bits");

    a_fmt_six: assert property (@(posedge clk) disable iff (reset) // RULE12
      (cif[g].wr_hi && cif[g].ctl.mode == DDU_UPD_HIWRITE && cif[g].ctl.fmt == 3'b010)
        |=> cif[g].code == {$past(sfr_wdata[5:0]), $past(cif[g].lo[7:2])})
      else $error("format 010 misplaced bits");

    a_fmt_seven: assert property (@(posedge clk) disable iff (reset) // RULE13
      (cif[g].wr_hi && cif[g].ctl.mode == DDU_UPD_HIWRITE && cif[g].ctl.fmt == 3'b011)
        |=> cif[g].code == {$past(sfr_wdata[6:0]), $past(cif[g].lo[7:3])})
      else $error("format 011 misplaced bits");

    a_reset_values: assert property (@(posedge clk) // RULE18
      reset |=> (cif[g].ctl == DDU_CTL_RESET && cif[g].lo == DDU_BYTE_RESET))
      else $error("channel registers not cleared by reset");
  end

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  // Read data is registered so every bus output comes from a flop;
  // unmapped addresses and pages read back zero
  always_comb begin
    st_d = st_q;
    if (sfr_rd) begin
      st_d.rdata = DDU_UNMAPPED_READ;
      if (sfr_page == DDU_CHAN0_PAGE) begin
        case (sfr_addr)
          DDU_CTL_ADDR: st_d.rdata = cif[0].ctl; // RULE15
          DDU_HI_ADDR: st_d.rdata = cif[0].hi;
          DDU_LO_ADDR: st_d.rdata = cif[0].lo;
          default: st_d.rdata = DDU_UNMAPPED_READ;
        endcase
      end else if (sfr_page == DDU_CHAN1_PAGE) begin
        case (sfr_addr)
          DDU_CTL_ADDR: st_d.rdata = cif[1].ctl; // RULE18
          DDU_HI_ADDR: st_d.rdata = cif[1].hi;
          DDU_LO_ADDR: st_d.rdata = cif[1].lo; // RULE17
          default: st_d.rdata = DDU_UNMAPPED_READ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      st_q.rdata <= DDU_UNMAPPED_READ;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Enable low puts the converter pin in high impedance and powers it down
  assign chan0_enable = cif[0].ctl.en; // RULE2 RULE3
  assign chan1_enable = cif[1].ctl.en; // RULE2 RULE3
  assign chan0_code = cif[0].code; // RULE1
  assign chan1_code = cif[1].code;
  assign sfr_rdata = st_q.rdata;

  a_read_control: assert property (@(posedge clk) disable iff (reset) // RULE15
    (sfr_rd && sfr_page == DDU_CHAN1_PAGE && sfr_addr == DDU_CTL_ADDR) |=>
      (sfr_rdata == $past(cif[1].ctl) && sfr_rdata[6:5] == 2'b00))
    else $error("control read back wrong");

  a_chan_separate: assert property (@(posedge clk) disable iff (reset) // RULE16
    (sfr_wr && sfr_page == DDU_CHAN0_PAGE) |=> $stable(cif[1].ctl) && $stable(cif[1].lo))
    else $error("channel 0 write disturbed channel 1");

  a_enable_follows: assert property (@(posedge clk) disable iff (reset) // RULE2 RULE3
    (sfr_wr && sfr_page == DDU_CHAN0_PAGE && sfr_addr == DDU_CTL_ADDR) |=>
      chan0_enable == $past(sfr_wdata[DDU_EN_BIT]))
    else $error("channel 0 enable does not follow control bit");

  a_enable_chan1: assert property (@(posedge clk) disable iff (reset) // RULE2 RULE3
    (sfr_wr && sfr_page == DDU_CHAN1_PAGE && sfr_addr == DDU_CTL_ADDR) |=>
      chan1_enable == $past(sfr_wdata[DDU_EN_BIT]))
    else $error("channel 1 enable does not follow control bit");

endmodule

// ### tb/ddu_cpu_model.sv
/*
  Behavioural processor core driving the register bus of the update block.
  Assumes callers enter its tasks just after a rising edge of clk.
*/
`timescale 1ns/1ns
module ddu_cpu_model (
  // Clock
  input wire logic clk,
  // Register bus
  output logic [7:0] sfr_page,
  output logic [7:0] sfr_addr,
  output logic sfr_wr,
  output logic sfr_rd,
  output logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata
);
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Idle bus at time zero
  initial begin
    sfr_page = 8'h00;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
  end

  // Write held over its sampling edge; released lines show the inverse
  task automatic wr_reg(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] d);
    sfr_page <= pg;
    sfr_addr <= ad;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
    sfr_page <= ~pg;
    sfr_addr <= ~ad;
    sfr_wdata <= ~d;
    @(posedge clk);
  endtask

  // Read; data is registered, so it is taken one edge after the strobe
  task automatic rd_reg(input logic [7:0] pg, input logic [7:0] ad, output logic [7:0] d);
    sfr_page <= pg;
    sfr_addr <= ad;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    sfr_page <= ~pg;
    sfr_addr <= ~ad;
    @(posedge clk);
    d = sfr_rdata;
  endtask
endmodule

// ### tb/tb_dual_dac_update_control.sv
/*
  Self-checking bench for the dual converter update control block.
  Assumes the register map and latencies of the design package.
*/
`timescale 1ns/1ns
module tb_dual_dac_update_control
  import ddu_pkg::*;
;
  logic clk;
  logic reset;
  logic [7:0] pg, ad, wd, rdata;
  logic wr, rd;
  logic [2:0] tmr;
  logic [11:0] code0, code1;
  logic en0, en1;
  int n_errors = 0;
  int checked = 0;

  ddu_top u_dut (.clk(clk), .reset(reset), .sfr_page(pg), .sfr_addr(ad), .sfr_wr(wr),
    .sfr_rd(rd), .sfr_wdata(wd), .sfr_rdata(rdata), .tmr2_ovf(tmr[0]), .tmr3_ovf(tmr[1]),
    .tmr4_ovf(tmr[2]), .chan0_code(code0), .chan1_code(code1), .chan0_enable(en0),
    .chan1_enable(en1));
  ddu_cpu_model u_cpu (.clk(clk), .sfr_page(pg), .sfr_addr(ad), .sfr_wr(wr), .sfr_rd(rd),
    .sfr_wdata(wd), .sfr_rdata(rdata));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Window of the 16-bit pair; top format bit pins the window at the top
  function automatic logic [11:0] want(logic [7:0] h, logic [7:0] l, logic [2:0] f);
    logic [15:0] w;
    w = {h, l};
    return w[11 + (f[2] ? 4 : int'(f[1:0])) -: 12];
  endfunction

  function automatic logic [11:0] code(input int ch);
    return ch ? code1 : code0;
  endfunction

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Timer pulses, bit order {timer 4, timer 3, timer 2}
  task automatic pulse(input logic [2:0] t);
    tmr <= t;
    @(posedge clk);
    tmr <= 3'b000;
    @(posedge clk);
  endtask

  task automatic finish_test();
    if (n_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_state();
    logic [7:0] d;
    chk("en0", 12'h000, {11'h0, en0});
    u_cpu.rd_reg(DDU_CHAN0_PAGE, DDU_CTL_ADDR, d);
    chk("ctl0", 12'h000, {4'h0, d});
    u_cpu.rd_reg(DDU_CHAN1_PAGE, DDU_CTL_ADDR, d);
    chk("ctl1", 12'h000, {4'h0, d});
    u_cpu.rd_reg(DDU_CHAN1_PAGE, DDU_LO_ADDR, d);
    chk("lo1", 12'h000, {4'h0, d});
    u_cpu.wr_reg(DDU_CHAN1_PAGE, DDU_LO_ADDR, 8'h5a);
    u_cpu.rd_reg(DDU_CHAN1_PAGE, DDU_LO_ADDR, d);
    chk("lo1 rw", 12'h05a, {4'h0, d});
    u_cpu.rd_reg(DDU_CHAN0_PAGE, 8'h55, d);
    chk("unmapped", {4'h0, DDU_UNMAPPED_READ}, {4'h0, d});
    u_cpu.wr_reg(8'h02, DDU_CTL_ADDR, 8'hff);
    u_cpu.rd_reg(8'h02, DDU_CTL_ADDR, d);
    chk("unmapped page", {4'h0, DDU_UNMAPPED_READ}, {4'h0, d});
    chk("en stray", 12'h000, {10'h0, en1, en0});
  endtask

  // Unused bits read zero; bit 7 drives the enable output
  task automatic t_ctl_fields();
    logic [7:0] d;
    for (int ch = 0; ch < 2; ch++) begin
      u_cpu.wr_reg(8'(ch), DDU_CTL_ADDR, 8'hff);
      u_cpu.rd_reg(8'(ch), DDU_CTL_ADDR, d);
      chk("ctl ones", 12'h09f, {4'h0, d});
      chk("en on", 12'h001, {11'h0, ch ? en1 : en0});
      u_cpu.wr_reg(8'(ch), DDU_CTL_ADDR, 8'h00);
      chk("en off", 12'h000, {11'h0, ch ? en1 : en0});
    end
  endtask

  // Low byte only stored; high write updates in every format; other channel idle
  task automatic t_hi_write();
    logic [7:0] h, l;
    logic [11:0] was, other;
    for (int ch = 0; ch < 2; ch++) begin
      for (int f = 0; f < 8; f++) begin
        l = 8'(8'ha5 + f * 17);
        h = 8'(8'h3c + f * 29);
        u_cpu.wr_reg(8'(ch), DDU_CTL_ADDR, 8'(f));
        was = code(ch);
        other = code(1 - ch);
        u_cpu.wr_reg(8'(ch), DDU_LO_ADDR, l);
        chk("lo held", was, code(ch));
        u_cpu.wr_reg(8'(ch), DDU_HI_ADDR, h);
        chk("hi upd", want(h, l, 3'(f)), code(ch));
        chk("other", other, code(1 - ch));
      end
      u_cpu.wr_reg(8'(ch), DDU_CTL_ADDR, 8'h00);
      for (int v = 0; v < 2; v++) begin
        u_cpu.wr_reg(8'(ch), DDU_LO_ADDR, v ? 8'h00 : 8'hff);
        u_cpu.wr_reg(8'(ch), DDU_HI_ADDR, v ? 8'h00 : 8'h0f);
        chk("range", v ? 12'h000 : 12'hfff, code(ch));
      end
    end
  endtask

  // Low byte set once, then high writes only
  task automatic t_eight_bit();
    logic [7:0] h;
    u_cpu.wr_reg(DDU_CHAN0_PAGE, DDU_CTL_ADDR, 8'h04);
    u_cpu.wr_reg(DDU_CHAN0_PAGE, DDU_LO_ADDR, 8'h00);
    for (int i = 0; i < 3; i++) begin
      h = 8'(i * 127);
      u_cpu.wr_reg(DDU_CHAN0_PAGE, DDU_HI_ADDR, h);
      chk("8bit", {h, 4'h0}, code0);
    end
  endtask

  // Held bytes move only on the selected overflow, using the format then in force
  task automatic t_timer();
    logic [7:0] h, l;
    logic [2:0] sel;
    logic [1:0] m;
    logic [11:0] was;
    for (int ch = 0; ch < 2; ch++) begin
      for (int k = 1; k < 4; k++) begin
        m = 2'(k);
        sel = (k == 1) ? 3'b010 : (k == 2) ? 3'b100 : 3'b001;
        l = 8'(8'h6c + k * 33 + ch);
        h = 8'(8'h93 - k * 21);
        u_cpu.wr_reg(8'(ch), DDU_CTL_ADDR, {3'b000, m, 3'b010});
        was = code(ch);
        u_cpu.wr_reg(8'(ch), DDU_LO_ADDR, l);
        u_cpu.wr_reg(8'(ch), DDU_HI_ADDR, h);
        chk("tmr held", was, code(ch));
        pulse(~sel);
        chk("tmr unsel", was, code(ch));
        u_cpu.wr_reg(8'(ch), DDU_CTL_ADDR, {3'b000, m, 3'b011});
        pulse(sel);
        chk("tmr upd", want(h, l, 3'b011), code(ch));
      end
    end
  endtask

  // ----------------------------------------------------------------
  // Clock, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    reset = 1'b1;
    tmr = 3'b000;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset_state();
    t_ctl_fields();
    t_hi_write();
    t_eight_bit();
    t_timer();
    finish_test();
  end

  // Cuts a hang short well inside the cycle budget
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    finish_test();
  end
endmodule
